// *** vref_ctrl_pkg.sv ***
// package: register map, field layout and reset values for the reference control
package vref_ctrl_pkg;
  localparam logic [11:0] ADDR_PORT_A_DIR = 12'h214;
  localparam logic [11:0] ADDR_REF_CTRL = 12'h27c;
  localparam int PORT_A_DIR_INDEX = 'h85;
  localparam int REF_CTRL_INDEX = 'h9f;
  localparam logic [7:0] PORT_A_DIR_RESET = 8'h1f;
  localparam logic [7:0] PORT_A_DIR_MASK = 8'h1f;
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  localparam logic [7:0] REF_CTRL_MASK = 8'hef;
  localparam int REF_ON_BIT = 7;
  localparam int REF_PIN_OUT_EN_BIT = 6;
  localparam int REF_RANGE_SEL_BIT = 5;
  localparam int REF_TAP_LSB = 0;
  localparam int REF_TAP_W = 4;
  localparam int PIN2_TRISTATE_BIT = 2;
endpackage

// *** vref_ctrl.sv ***
// reference control block with apb register slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: any reset clears the reference enable bit, switching the reference off.
// R2: any reset clears the pin output enable bit, disconnecting the pin.
// R3: any reset clears the range select bit, selecting the high range.
// R4: any reset clears the four tap select bits.
// R5: waking from sleep leaves all control fields unchanged.
// R6: reference reaches the pin only when pin2 tristate and pin output enable set.
// R7: enable, range and tap never depend on comparator mode.
// R8: unimplemented bits ignore writes and read as zero.
// R9: software should clear the enable bit before sleep.
// R10: ladder controls are static levels changing only on write or reset.
// R11: range bit one selects low range, zero selects high range.
module vref_ctrl
  import vref_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog ladder controls
  output logic ref_on_o,
  output logic ref_low_range_o,
  output logic [REF_TAP_W-1:0] ref_tap_sel_o,
  // shared pin routing
  output logic shared_ref_pin_connect_o,
  output logic [4:0] port_a_direction_o
);

  // ----------------------------------------
  // widths and lane positions
  // ----------------------------------------
  localparam int REG_W = 8;
  localparam int DIR_W = 5;
  localparam int DATA_W = 32;
  localparam int PAD_W = DATA_W - REG_W;
  localparam int LANE0 = 0;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic access;
  logic hit_ref;
  logic hit_dir;
  logic hit_any;
  logic lane0_en;
  logic wr_ref;
  logic wr_dir;
  logic rd_ref;
  logic rd_dir;
  logic [REG_W-1:0] wr_byte;

  // closing cycle of an access never starts a second one
  assign access = psel_i & penable_i & ~pready_o;
  assign hit_ref = (paddr_i == ADDR_REF_CTRL);
  assign hit_dir = (paddr_i == ADDR_PORT_A_DIR);
  assign hit_any = hit_ref | hit_dir;
  // only the low byte lane carries register bits
  assign lane0_en = pstrb_i[LANE0];
  assign wr_ref = access & pwrite_i & hit_ref & lane0_en;
  assign wr_dir = access & pwrite_i & hit_dir & lane0_en;
  assign rd_ref = access & ~pwrite_i & hit_ref;
  assign rd_dir = access & ~pwrite_i & hit_dir;
  assign wr_byte = pwdata_i[REG_W-1:0];

  // ----------------------------------------
  // reference enable field
  // ----------------------------------------
  logic ref_on;
  logic next_ref_on;

  // no sleep input reaches this block, so a wake keeps every field
  always_comb begin
    next_ref_on = ref_on; // R5
    if (wr_ref) begin
      next_ref_on = wr_byte[REF_ON_BIT]; // R10
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_on <= REF_CTRL_RESET[REF_ON_BIT]; // R1
    end else begin
      ref_on <= next_ref_on;
    end
  end

  // ----------------------------------------
  // pin output enable field
  // ----------------------------------------
  logic ref_pin_out_en;
  logic next_ref_pin_out_en;

  always_comb begin
    next_ref_pin_out_en = ref_pin_out_en; // R5
    if (wr_ref) begin
      next_ref_pin_out_en = wr_byte[REF_PIN_OUT_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_pin_out_en <= REF_CTRL_RESET[REF_PIN_OUT_EN_BIT]; // R2
    end else begin
      ref_pin_out_en <= next_ref_pin_out_en;
    end
  end

  // ----------------------------------------
  // range select field
  // ----------------------------------------
  logic ref_range_sel;
  logic next_ref_range_sel;

  always_comb begin
    next_ref_range_sel = ref_range_sel; // R5
    if (wr_ref) begin
      next_ref_range_sel = wr_byte[REF_RANGE_SEL_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_range_sel <= REF_CTRL_RESET[REF_RANGE_SEL_BIT]; // R3
    end else begin
      ref_range_sel <= next_ref_range_sel;
    end
  end

  // ----------------------------------------
  // tap select field
  // ----------------------------------------
  logic [REF_TAP_W-1:0] ref_tap_sel;
  logic [REF_TAP_W-1:0] next_ref_tap_sel;

  always_comb begin
    next_ref_tap_sel = ref_tap_sel; // R5
    if (wr_ref) begin
      next_ref_tap_sel = wr_byte[REF_TAP_LSB +: REF_TAP_W]; // R10
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_tap_sel <= REF_CTRL_RESET[REF_TAP_LSB +: REF_TAP_W]; // R4
    end else begin
      ref_tap_sel <= next_ref_tap_sel;
    end
  end

  // ----------------------------------------
  // port direction bits
  // ----------------------------------------
  logic [DIR_W-1:0] pin_dir;
  logic [DIR_W-1:0] next_pin_dir;

  // only the low five bits are stored; the rest cost nothing and read zero
  always_comb begin
    next_pin_dir = pin_dir;
    if (wr_dir) begin
      next_pin_dir = wr_byte[DIR_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_dir <= PORT_A_DIR_RESET[DIR_W-1:0];
    end else begin
      pin_dir <= next_pin_dir;
    end
  end

  // ----------------------------------------
  // register read views
  // ----------------------------------------
  logic [REG_W-1:0] ref_ctrl_reg;
  logic [REG_W-1:0] port_a_direction;

  // unimplemented bits are never stored, so writes to them are lost
  always_comb begin
    ref_ctrl_reg = '0; // R8
    ref_ctrl_reg[REF_ON_BIT] = ref_on;
    ref_ctrl_reg[REF_PIN_OUT_EN_BIT] = ref_pin_out_en;
    ref_ctrl_reg[REF_RANGE_SEL_BIT] = ref_range_sel;
    ref_ctrl_reg[REF_TAP_LSB +: REF_TAP_W] = ref_tap_sel;
  end

  always_comb begin
    port_a_direction = '0; // R8
    port_a_direction[DIR_W-1:0] = pin_dir;
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  logic next_pready;
  logic next_pslverr;

  // exactly one wait state on every access, mapped or not
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (access) begin
      next_pready = 1'b1;
      next_pslverr = ~hit_any;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [DATA_W-1:0] next_prdata;

  // zero outside the answer cycle, so stale data never lingers on the bus
  always_comb begin
    next_prdata = '0;
    if (rd_ref) begin
      next_prdata = {{PAD_W{1'b0}}, ref_ctrl_reg}; // R8
    end else if (rd_dir) begin
      next_prdata = {{PAD_W{1'b0}}, port_a_direction}; // R8
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= '0;
    end else begin
      prdata_o <= next_prdata;
    end
  end

  // ----------------------------------------
  // ladder controls
  // ----------------------------------------
  logic next_ladder_on;
  logic next_ladder_low;
  logic [REF_TAP_W-1:0] next_ladder_tap;

  // fed from next field values, so the ladder moves on the write edge itself
  // no comparator mode input exists, so these levels cannot depend on it
  always_comb begin
    next_ladder_on = next_ref_on; // R7
    next_ladder_low = next_ref_range_sel; // R11
    next_ladder_tap = next_ref_tap_sel; // R10
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_on_o <= REF_CTRL_RESET[REF_ON_BIT];
      ref_low_range_o <= REF_CTRL_RESET[REF_RANGE_SEL_BIT];
      ref_tap_sel_o <= REF_CTRL_RESET[REF_TAP_LSB +: REF_TAP_W];
    end else begin
      ref_on_o <= next_ladder_on;
      ref_low_range_o <= next_ladder_low;
      ref_tap_sel_o <= next_ladder_tap;
    end
  end

  // ----------------------------------------
  // shared pin routing
  // ----------------------------------------
  logic next_pin_connect;
  logic [DIR_W-1:0] next_dir_copy;

  // both conditions needed; either one alone leaves the pin to port logic
  always_comb begin
    next_pin_connect = next_ref_pin_out_en & next_pin_dir[PIN2_TRISTATE_BIT]; // R6
    next_dir_copy = next_pin_dir;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shared_ref_pin_connect_o <= REF_CTRL_RESET[REF_PIN_OUT_EN_BIT]
                                  & PORT_A_DIR_RESET[PIN2_TRISTATE_BIT];
      port_a_direction_o <= PORT_A_DIR_RESET[DIR_W-1:0];
    end else begin
      shared_ref_pin_connect_o <= next_pin_connect;
      port_a_direction_o <= next_dir_copy;
    end
  end

endmodule
`default_nettype wire

// *** vref_ladder.sv ***
// ladder stand-in: level code seen at the shared pin
`timescale 1ns/1ps
`default_nettype none
module vref_ladder (input wire logic en_i, input wire logic [3:0] tap_i, output logic [4:0] v_o);
  // open pin shows a fixed pattern, never the last code
  assign v_o = en_i ? {1'b1, tap_i} : 5'h0a;
endmodule
`default_nettype wire

// *** vref_ctrl_props.sv ***
// concurrent checks on the reference control ports
`timescale 1ns/1ps
`default_nettype none
module vref_ctrl_props (input wire logic clk_sys_i, resetn_i, pready_o, ref_on_o,
  ref_low_range_o, shared_ref_pin_connect_o, input wire logic [3:0] ref_tap_sel_o,
  input wire logic [31:0] prdata_o, input wire logic [4:0] port_a_direction_o);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  property p_on; $rose(resetn_i) |-> !ref_on_o; endproperty
  a_on: assert property (p_on) else $error("on");
  property p_oe; $rose(resetn_i) |-> !shared_ref_pin_connect_o; endproperty
  a_oe: assert property (p_oe) else $error("pin");
  property p_rg; $rose(resetn_i) |-> !ref_low_range_o; endproperty
  a_rg: assert property (p_rg) else $error("range");
  property p_tp; $rose(resetn_i) |-> ref_tap_sel_o == 0; endproperty
  a_tp: assert property (p_tp) else $error("tap");
  property p_pin; shared_ref_pin_connect_o |-> port_a_direction_o[2]; endproperty
  a_pin: assert property (p_pin) else $error("route");
  property p_rd; pready_o |-> prdata_o[31:8] == 0; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_st; !pready_o |-> $stable(ref_tap_sel_o); endproperty
  a_st: assert property (p_st) else $error("tap hold");
  property p_kp; !pready_o |-> $stable({ref_on_o, ref_low_range_o}); endproperty
  a_kp: assert property (p_kp) else $error("hold");
  sequence s_no_answer; !pready_o ##1 !pready_o; endsequence
  property p_quiet; s_no_answer |-> $stable({ref_on_o, ref_low_range_o, ref_tap_sel_o,
    shared_ref_pin_connect_o, port_a_direction_o}); endproperty
  a_quiet: assert property (p_quiet) else $error("outputs moved without an answer");
endmodule
bind vref_ctrl vref_ctrl_props u_props (.*);
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the reference control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vref_ctrl_pkg::*;
  logic clk_sys_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, er;
  logic pready_o, pslverr_o, ref_on_o, ref_low_range_o, shared_ref_pin_connect_o;
  logic [3:0] pstrb_i = 1, ref_tap_sel_o;
  logic [4:0] port_a_direction_o, lv;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [15:0] v = 16'h8292;
  logic [7:0] c = 0, d = 8'h1f;
  int err_count = 0, n_checks = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  vref_ctrl dut (.*);
  vref_ladder u_lad (.en_i(ref_on_o & shared_ref_pin_connect_o), .tap_i(ref_tap_sel_o), .v_o(lv));
  task automatic chk(input logic [39:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, s, e);
    end
  endtask
  // lfsr step for the random stimulus
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop;
    $display("%0d checks, %0d errors", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // apb cycle: hold everything until pready is seen high
  task automatic io(input logic w, input logic [11:0] a, input logic [31:0] x);
    @(posedge clk_sys_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, x};
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1);
    {rd, er} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 0;
  endtask
  always @(posedge clk_sys_i) if (++cyc > 3000) begin
    err_count++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1;
    io(0, 12'h0, 0);
    chk({rd, er}, 1);
    for (int i = 0; i < 40; i++) begin
      // mid-run reset, model back to reset values
      if (i == 20) begin
        resetn_i <= 0;
        {c, d} = 16'h1f;
        @(posedge clk_sys_i) resetn_i <= 1;
      end
      io(0, ADDR_REF_CTRL, 0);
      chk({rd, er}, {c, 1'b0});
      io(0, ADDR_PORT_A_DIR, 0);
      chk({rd, er}, {d, 1'b0});
      v = lfsr(v);
      pstrb_i <= v[11:8];
      io(1, ADDR_REF_CTRL, v);
      io(1, ADDR_PORT_A_DIR, v >> 8);
      if (v[8]) {c, d} = {v[7:0] & REF_CTRL_MASK, v[15:8] & PORT_A_DIR_MASK};
      chk({ref_on_o, ref_low_range_o, ref_tap_sel_o, shared_ref_pin_connect_o, port_a_direction_o, lv},
        {c[7], c[5], c[3:0], c[6] & d[2], d[4:0], c[7] & c[6] & d[2] ? {1'b1, c[3:0]} : 5'h0a});
      if (i == 30) begin
        // software parks the reference before sleep
        pstrb_i <= 4'hf;
        c[REF_ON_BIT] = 1'b0;
        io(1, ADDR_REF_CTRL, {24'h00_0000, c});
        chk({ref_on_o, rd[31:8]}, {c[REF_ON_BIT], 24'h00_0000});
      end
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
